// file: common/pdg_pkg.sv
// Register map, field layout, reset values and serial-port states of the control slice
package pdg_pkg;

  // Register addresses on the serial port
  localparam logic [4:0] ADDR_VCO_BAND_AND_DRIVE      = 5'h08;
  localparam logic [4:0] ADDR_CLOCK_MULTIPLIER_SETUP  = 5'h09;
  localparam logic [4:0] ADDR_LOOP_FILTER_AND_TUNE    = 5'h0a;
  localparam logic [4:0] ADDR_INPHASE_GAIN_LOW        = 5'h0b;
  localparam logic [4:0] ADDR_INPHASE_GAIN_HIGH_PWR   = 5'h0c;
  localparam logic [4:0] ADDR_AUX_ONE_LEVEL_LOW       = 5'h0d;
  localparam logic [4:0] ADDR_AUX_ONE_LEVEL_HIGH_MODE = 5'h0e;
  localparam logic [4:0] ADDR_QUAD_GAIN_LOW           = 5'h0f;
  localparam logic [4:0] ADDR_QUAD_GAIN_HIGH_PWR      = 5'h10;

  // Writable bits of each register; reserved bits stay zero
  localparam logic [7:0] MASK_FULL      = 8'hff;
  localparam logic [7:0] MASK_LOOP_BW   = 8'h1f;
  localparam logic [7:0] MASK_GAIN_HIGH = 8'hc3;
  localparam logic [7:0] MASK_AUX_HIGH  = 8'he3;

  // Reset values
  localparam logic [7:0] RST_VCO_BAND_AND_DRIVE = 8'he7;  // Band 111001, strength 11
  localparam logic [7:0] RST_CLOCK_MULT_SETUP   = 8'h52;  // Off, divider 10, loop 10, bias 010
  localparam logic [7:0] RST_LOOP_FILTER        = 8'h1f;  // Bandwidth 11111
  localparam logic [7:0] RST_GAIN_LOW           = 8'hf9;
  localparam logic [7:0] RST_GAIN_HIGH_PWR      = 8'h01;
  localparam logic [7:0] RST_AUX_ONE            = 8'h00;

  // Field positions
  localparam int BAND_MSB      = 7;
  localparam int BAND_LSB      = 2;
  localparam int STRENGTH_MSB  = 1;
  localparam int PLL_EN_BIT    = 7;
  localparam int VCO_DIV_MSB   = 6;
  localparam int VCO_DIV_LSB   = 5;
  localparam int LOOP_DIV_MSB  = 4;
  localparam int LOOP_DIV_LSB  = 3;
  localparam int BIAS_MSB      = 2;
  localparam int LOOP_BW_MSB   = 4;
  localparam int SLEEP_BIT     = 7;
  localparam int PDN_BIT       = 6;
  localparam int SIGN_BIT      = 7;
  localparam int SINK_BIT      = 6;
  localparam int AUX_PDN_BIT   = 5;
  localparam int HIGH_MSB      = 1;

  // Divider ratio encodings: one code step doubles the ratio
  localparam logic [3:0] VCO_RATIO_BASE  = 4'h1;
  localparam logic [4:0] LOOP_RATIO_BASE = 5'h02;

  // Serial frame: instruction byte then one data byte, MSB first
  localparam int         READ_FLAG_BIT = 7;
  localparam int         ADDR_MSB      = 4;
  localparam logic [2:0] LAST_BIT      = 3'h7;
  localparam logic [2:0] CNT_ZERO      = 3'h0;
  localparam logic [2:0] CNT_ONE       = 3'h1;
  localparam logic [2:0] TUNE_ZERO     = 3'h0;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;

  typedef enum logic [3:0] {
    PDG_ST_INSTR = 4'b0001,
    PDG_ST_WRITE = 4'b0010,
    PDG_ST_READ  = 4'b0100,
    PDG_ST_DONE  = 4'b1000
  } pdg_state_t;

endpackage

// file: src/pdg_regs.sv
// Clock multiplier and converter gain control registers behind the 3-wire serial port
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Band select field, reset 111001
// - Enable picks PLL or reference clock
// - Oscillator divider code gives 1/2/4/8
// - Loop divider code gives 2/4/8/16
// - Read-only tuning voltage monitor code
// - In-phase gain split across two bytes
// - In-phase sleep and power-down bits
// - First aux current word across two bytes
// - Aux sign selects positive or negative pin
// - Aux direction selects source or sink
// - Aux power-down switches it off
// - Quadrature gain split across two bytes
module pdg_regs
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_sclk,
  input  wire logic       i_csb_n,
  input  wire logic       i_sdio,
  input  wire logic [2:0] i_tuning_voltage_monitor,
  output logic            o_sdio,
  output logic            o_sdio_oe,
  output logic [5:0]      o_band_select,
  output logic [1:0]      o_oscillator_output_strength,
  output logic            o_clk_src_pll,
  output logic [3:0]      o_oscillator_output_divider,
  output logic [4:0]      o_loop_divider_ratio,
  output logic [2:0]      o_vco_bias,
  output logic [4:0]      o_loop_bandwidth,
  output logic [9:0]      o_inphase_gain,
  output logic            o_inphase_sleep,
  output logic            o_inphase_pdn,
  output logic [9:0]      o_first_aux_current_word,
  output logic            o_first_aux_positive_pin_active,
  output logic            o_first_aux_negative_pin_active,
  output logic            o_first_aux_sink,
  output logic            o_first_aux_on,
  output logic [9:0]      o_quadrature_gain,
  output logic            o_quadrature_sleep,
  output logic            o_quadrature_pdn
);
  import pdg_pkg::*;

  logic [2:0] sclk_sync_ff;
  logic [1:0] csb_sync_ff;
  logic [1:0] sdio_sync_ff;
  logic [2:0] tune_s1_ff;
  logic [2:0] tune_s2_ff;
  pdg_state_t state_ff;
  pdg_state_t nxt_state;
  logic [2:0] cnt_ff;
  logic [7:0] shift_ff;
  logic [4:0] addr_ff;
  logic [7:0] r08_ff;
  logic [7:0] r09_ff;
  logic [7:0] r0a_ff;
  logic [7:0] r0b_ff;
  logic [7:0] r0c_ff;
  logic [7:0] r0d_ff;
  logic [7:0] r0e_ff;
  logic [7:0] r0f_ff;
  logic [7:0] r10_ff;
  logic [3:0] vco_ratio_ff;
  logic [4:0] loop_ratio_ff;
  logic       aux_pos_ff;
  logic       aux_neg_ff;
  logic       aux_on_ff;
  logic       sdio_oe_ff;

  // Pins are asynchronous to the system clock: two flops before use
  // The serial clock must hold each level for at least four system clocks
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sclk_sync_ff <= CNT_ZERO;
      csb_sync_ff  <= 2'h3;  // Deselected, matching the idle pin
      sdio_sync_ff <= 2'h0;
    end
    else
    begin
      sclk_sync_ff <= {sclk_sync_ff[1:0], i_sclk};  // Third stage only for edge detect
      csb_sync_ff  <= {csb_sync_ff[0], i_csb_n};
      sdio_sync_ff <= {sdio_sync_ff[0], i_sdio};
    end
  end

  // Monitor code synchroniser; the bits are not gray coded, so a read taken while
  // the code moves may show a mix for one sample, harmless for a slow analog readout
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tune_s1_ff <= TUNE_ZERO;
      tune_s2_ff <= TUNE_ZERO;
    end
    else
    begin
      tune_s1_ff <= i_tuning_voltage_monitor;
      tune_s2_ff <= tune_s1_ff;
    end
  end

  // Serial clock edges, seen from synchronised copies only
  wire sclk_rise  = sclk_sync_ff[1] & ~sclk_sync_ff[2];
  wire sclk_fall  = ~sclk_sync_ff[1] & sclk_sync_ff[2];
  wire frame_off  = csb_sync_ff[1];
  wire sdio_bit   = sdio_sync_ff[1];
  wire last_bit   = (cnt_ff == LAST_BIT);
  wire [7:0] shift_in = {shift_ff[6:0], sdio_bit};
  wire instr_done = (state_ff == PDG_ST_INSTR) && sclk_rise && last_bit;
  wire is_read    = shift_in[READ_FLAG_BIT];
  wire write_done = (state_ff == PDG_ST_WRITE) && sclk_rise && last_bit;

  // Read data mux; unmapped addresses and reserved bits read zero
  wire [4:0] rd_addr = shift_in[ADDR_MSB:0];
  logic [7:0] rd_data;
  always_comb
  begin
    case (rd_addr)
      ADDR_VCO_BAND_AND_DRIVE:      rd_data = r08_ff;
      ADDR_CLOCK_MULTIPLIER_SETUP:  rd_data = r09_ff;
      ADDR_LOOP_FILTER_AND_TUNE:    rd_data = {tune_s2_ff, r0a_ff[LOOP_BW_MSB:0]};
      ADDR_INPHASE_GAIN_LOW:        rd_data = r0b_ff;
      ADDR_INPHASE_GAIN_HIGH_PWR:   rd_data = r0c_ff;
      ADDR_AUX_ONE_LEVEL_LOW:       rd_data = r0d_ff;
      ADDR_AUX_ONE_LEVEL_HIGH_MODE: rd_data = r0e_ff;
      ADDR_QUAD_GAIN_LOW:           rd_data = r0f_ff;
      ADDR_QUAD_GAIN_HIGH_PWR:      rd_data = r10_ff;
      default:                      rd_data = BYTE_ZERO;
    endcase
  end

  // Frame sequencing; a raised chip select abandons any partial frame
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      PDG_ST_INSTR:
        if (instr_done)
          nxt_state = is_read ? PDG_ST_READ : PDG_ST_WRITE;
      PDG_ST_WRITE:
        if (sclk_rise && last_bit)
          nxt_state = PDG_ST_DONE;
      PDG_ST_READ:
        if (sclk_rise && last_bit)
          nxt_state = PDG_ST_DONE;
      PDG_ST_DONE:
        nxt_state = PDG_ST_DONE;  // Bits past the sixteenth wait here for chip select high
      default:
        nxt_state = PDG_ST_INSTR;
    endcase
    if (frame_off)
      nxt_state = PDG_ST_INSTR;
  end

  // Sequencer state and readback drive enable
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_ff   <= PDG_ST_INSTR;
      sdio_oe_ff <= 1'b0;
    end
    else
    begin
      state_ff   <= nxt_state;
      sdio_oe_ff <= (nxt_state == PDG_ST_READ);  // Drive only in the data phase of a read
    end
  end

  // Bit counter; wraps after the instruction byte so it also marks the data byte's end
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      cnt_ff <= CNT_ZERO;
    else if (frame_off)
      cnt_ff <= CNT_ZERO;
    else if (sclk_rise)
      cnt_ff <= cnt_ff + CNT_ONE;
  end

  // Shift conditions named so the clocked block below only selects
  wire       shift_capture = sclk_rise && (state_ff == PDG_ST_INSTR || state_ff == PDG_ST_WRITE);
  wire       shift_out     = sclk_fall && (state_ff == PDG_ST_READ) && (cnt_ff != CNT_ZERO);
  wire [7:0] load_byte     = is_read ? rd_data : BYTE_ZERO;

  // Shift register: instruction and write bits in on rises, read bits out on falls
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      shift_ff <= BYTE_ZERO;
      addr_ff  <= 5'h00;
    end
    else if (instr_done)
    begin
      addr_ff  <= rd_addr;
      shift_ff <= load_byte;  // MSB out before the first read edge
    end
    else if (shift_capture)
      shift_ff <= shift_in;  // Instruction bits shift in as well as write data
    else if (shift_out)
      shift_ff <= {shift_ff[6:0], 1'b0};  // Change on falling edge, host samples on rising
  end

  // Write strobes per register
  // Strobes fire once, on the sixteenth rise; later bits wait for chip select high
  wire we_08 = write_done && (addr_ff == ADDR_VCO_BAND_AND_DRIVE);
  wire we_09 = write_done && (addr_ff == ADDR_CLOCK_MULTIPLIER_SETUP);
  wire we_0a = write_done && (addr_ff == ADDR_LOOP_FILTER_AND_TUNE);
  wire we_0b = write_done && (addr_ff == ADDR_INPHASE_GAIN_LOW);
  wire we_0c = write_done && (addr_ff == ADDR_INPHASE_GAIN_HIGH_PWR);
  wire we_0d = write_done && (addr_ff == ADDR_AUX_ONE_LEVEL_LOW);
  wire we_0e = write_done && (addr_ff == ADDR_AUX_ONE_LEVEL_HIGH_MODE);
  wire we_0f = write_done && (addr_ff == ADDR_QUAD_GAIN_LOW);
  wire we_10 = write_done && (addr_ff == ADDR_QUAD_GAIN_HIGH_PWR);

  // Register file; reserved bits are masked so they always read zero
  // Each byte lands alone, so a 10-bit word shows mixed halves between its two writes
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      r08_ff <= RST_VCO_BAND_AND_DRIVE;
      r09_ff <= RST_CLOCK_MULT_SETUP;
      r0a_ff <= RST_LOOP_FILTER;
      r0b_ff <= RST_GAIN_LOW;
      r0c_ff <= RST_GAIN_HIGH_PWR;
      r0d_ff <= RST_AUX_ONE;
      r0e_ff <= RST_AUX_ONE;
      r0f_ff <= RST_GAIN_LOW;
      r10_ff <= RST_GAIN_HIGH_PWR;
    end
    else
    begin
      if (we_08) r08_ff <= shift_in & MASK_FULL;
      if (we_09) r09_ff <= shift_in & MASK_FULL;
      if (we_0a) r0a_ff <= shift_in & MASK_LOOP_BW;
      if (we_0b) r0b_ff <= shift_in & MASK_FULL;
      if (we_0c) r0c_ff <= shift_in & MASK_GAIN_HIGH;
      if (we_0d) r0d_ff <= shift_in & MASK_FULL;
      if (we_0e) r0e_ff <= shift_in & MASK_AUX_HIGH;
      if (we_0f) r0f_ff <= shift_in & MASK_FULL;
      if (we_10) r10_ff <= shift_in & MASK_GAIN_HIGH;
    end
  end

  // Decoded controls get their own flops so every output is a flop; one cycle behind
  // Their reset values derive from the register defaults so the two never disagree
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      vco_ratio_ff  <= VCO_RATIO_BASE << RST_CLOCK_MULT_SETUP[VCO_DIV_MSB:VCO_DIV_LSB];
      loop_ratio_ff <= LOOP_RATIO_BASE << RST_CLOCK_MULT_SETUP[LOOP_DIV_MSB:LOOP_DIV_LSB];
      aux_pos_ff    <= ~RST_AUX_ONE[SIGN_BIT];
      aux_neg_ff    <= RST_AUX_ONE[SIGN_BIT];
      aux_on_ff     <= ~RST_AUX_ONE[AUX_PDN_BIT];
    end
    else
    begin
      vco_ratio_ff  <= VCO_RATIO_BASE << r09_ff[VCO_DIV_MSB:VCO_DIV_LSB];
      loop_ratio_ff <= LOOP_RATIO_BASE << r09_ff[LOOP_DIV_MSB:LOOP_DIV_LSB];
      aux_pos_ff    <= ~r0e_ff[SIGN_BIT];
      aux_neg_ff    <= r0e_ff[SIGN_BIT];
      aux_on_ff     <= ~r0e_ff[AUX_PDN_BIT];
    end
  end

  // Static control outputs
  // All come straight from flops, so the analog side never sees decode glitches
  assign o_sdio                          = shift_ff[READ_FLAG_BIT];
  assign o_sdio_oe                       = sdio_oe_ff;
  assign o_band_select                   = r08_ff[BAND_MSB:BAND_LSB];
  assign o_oscillator_output_strength    = r08_ff[STRENGTH_MSB:0];
  assign o_clk_src_pll                   = r09_ff[PLL_EN_BIT];
  assign o_oscillator_output_divider     = vco_ratio_ff;
  assign o_loop_divider_ratio            = loop_ratio_ff;
  assign o_vco_bias                      = r09_ff[BIAS_MSB:0];
  assign o_loop_bandwidth                = r0a_ff[LOOP_BW_MSB:0];
  assign o_inphase_gain                  = {r0c_ff[HIGH_MSB:0], r0b_ff};
  assign o_inphase_sleep                 = r0c_ff[SLEEP_BIT];
  assign o_inphase_pdn                   = r0c_ff[PDN_BIT];
  assign o_first_aux_current_word        = {r0e_ff[HIGH_MSB:0], r0d_ff};
  assign o_first_aux_positive_pin_active = aux_pos_ff;
  assign o_first_aux_negative_pin_active = aux_neg_ff;
  assign o_first_aux_sink                = r0e_ff[SINK_BIT];
  assign o_first_aux_on                  = aux_on_ff;
  assign o_quadrature_gain               = {r10_ff[HIGH_MSB:0], r0f_ff};
  assign o_quadrature_sleep              = r10_ff[SLEEP_BIT];
  assign o_quadrature_pdn                = r10_ff[PDN_BIT];

endmodule
`default_nettype wire

// file: verification/pdg_regs_sva.sv
// Port-level assertions for the clock multiplier and gain control slice
`timescale 1ns/1ps
`default_nettype none
module pdg_regs_sva
(
  input wire logic       i_clk_sys,
  input wire logic       i_nrst,
  input wire logic       i_csb_n,
  input wire logic       o_sdio_oe,
  input wire logic       o_clk_src_pll,
  input wire logic [3:0] o_oscillator_output_divider,
  input wire logic [4:0] o_loop_divider_ratio,
  input wire logic [9:0] o_inphase_gain,
  input wire logic [9:0] o_quadrature_gain,
  input wire logic [9:0] o_first_aux_current_word,
  input wire logic       o_first_aux_positive_pin_active,
  input wire logic       o_first_aux_negative_pin_active
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // Port idle long enough that no write or decode can still be landing
  sequence s_idle;
    i_csb_n[*6];
  endsequence
  a_osc_div_code: assert property (
    o_oscillator_output_divider inside {4'h1, 4'h2, 4'h4, 4'h8})
    else $error("oscillator divider not a legal ratio");
  a_loop_ratio_code: assert property (
    o_loop_divider_ratio inside {5'h02, 5'h04, 5'h08, 5'h10})
    else $error("loop divider not a legal ratio");
  a_aux_pin_excl: assert property (
    o_first_aux_positive_pin_active != o_first_aux_negative_pin_active)
    else $error("aux pins not exclusive");
  a_gain_idle_stable: assert property (
    s_idle |=> $stable(o_inphase_gain) && $stable(o_quadrature_gain))
    else $error("gain moved while port idle");
  a_aux_idle_stable: assert property (
    s_idle |=> $stable(o_first_aux_current_word))
    else $error("aux word moved while port idle");
  a_pll_idle_stable: assert property (
    s_idle |=> $stable({o_clk_src_pll, o_loop_divider_ratio}))
    else $error("clock setup moved while port idle");
  a_oe_in_frame: assert property ($rose(o_sdio_oe) |-> !i_csb_n)
    else $error("readback driven outside a frame");
  a_oe_holds: assert property ($rose(o_sdio_oe) |-> o_sdio_oe[*8])
    else $error("readback drive dropped early");
  a_oe_release: assert property ($rose(i_csb_n) |-> ##[1:4] !o_sdio_oe)
    else $error("readback drive held after frame end");
endmodule
bind pdg_regs pdg_regs_sva u_sva (.*);
`default_nettype wire

// file: verification/pdg_regs_tb.sv
// Self-checking bench for the control slice, driven over the 3-wire port
`timescale 1ns/1ps
`default_nettype none
module pdg_regs_tb;
  logic clk, nrst, sclk, csb_n, host_sdio, o_sdio, o_sdio_oe, o_clk_src_pll;
  logic [2:0] tune, o_vco_bias;
  logic [5:0] o_band_select;
  logic [1:0] o_oscillator_output_strength;
  logic [3:0] o_oscillator_output_divider;
  logic [4:0] o_loop_divider_ratio, o_loop_bandwidth;
  logic [9:0] o_inphase_gain, o_first_aux_current_word, o_quadrature_gain;
  logic o_inphase_sleep, o_inphase_pdn, o_first_aux_positive_pin_active;
  logic o_first_aux_negative_pin_active, o_first_aux_sink, o_first_aux_on;
  logic o_quadrature_sleep, o_quadrature_pdn;
  logic [7:0] d;
  int n_fail = 0;
  int compares = 0;
  // Rows: address, write data, expected readback
  logic [23:0] rows [11] = '{24'h08a5a5, 24'h09dbdb, 24'h0aff7f, 24'h0b5a5a, 24'h0cffc3,
    24'h0d3c3c, 24'h0effe3, 24'h0f9696, 24'h10ffc3, 24'h11ff00, 24'h07ff00};
  // Shared sdio wire: the device wins while it drives
  wire sdio_w = o_sdio_oe ? o_sdio : host_sdio;
  wire [15:0] w_vco = {8'h0, o_band_select, o_oscillator_output_strength};
  wire [15:0] w_clk = {3'h0, o_clk_src_pll, o_oscillator_output_divider, o_loop_divider_ratio,
    o_vco_bias};
  wire [15:0] w_bw = {11'h0, o_loop_bandwidth};
  wire [15:0] w_i = {4'h0, o_inphase_sleep, o_inphase_pdn, o_inphase_gain};
  wire [15:0] w_q = {4'h0, o_quadrature_sleep, o_quadrature_pdn, o_quadrature_gain};
  wire [15:0] w_aux = {2'h0, o_first_aux_positive_pin_active, o_first_aux_negative_pin_active,
    o_first_aux_sink, o_first_aux_on, o_first_aux_current_word};
  pdg_regs DUT (.i_clk_sys(clk), .i_nrst(nrst), .i_sclk(sclk), .i_csb_n(csb_n),
    .i_sdio(sdio_w), .i_tuning_voltage_monitor(tune), .o_sdio(o_sdio), .o_sdio_oe(o_sdio_oe),
    .o_band_select(o_band_select), .o_oscillator_output_strength(o_oscillator_output_strength),
    .o_clk_src_pll(o_clk_src_pll), .o_oscillator_output_divider(o_oscillator_output_divider),
    .o_loop_divider_ratio(o_loop_divider_ratio), .o_vco_bias(o_vco_bias),
    .o_loop_bandwidth(o_loop_bandwidth), .o_inphase_gain(o_inphase_gain),
    .o_inphase_sleep(o_inphase_sleep), .o_inphase_pdn(o_inphase_pdn),
    .o_first_aux_current_word(o_first_aux_current_word),
    .o_first_aux_positive_pin_active(o_first_aux_positive_pin_active),
    .o_first_aux_negative_pin_active(o_first_aux_negative_pin_active),
    .o_first_aux_sink(o_first_aux_sink), .o_first_aux_on(o_first_aux_on),
    .o_quadrature_gain(o_quadrature_gain), .o_quadrature_sleep(o_quadrature_sleep),
    .o_quadrature_pdn(o_quadrature_pdn));
  // 100 ns clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask
  task automatic chk_all(input logic [15:0] ev, ec, eb, ei, eq, ea);
    @(negedge clk);
    chk("vco", w_vco, ev);
    chk("clk", w_clk, ec);
    chk("bw", w_bw, eb);
    chk("igain", w_i, ei);
    chk("qgain", w_q, eq);
    chk("aux", w_aux, ea);
    @(posedge clk);  // Hand back on a rising edge so the next drive lands there
  endtask
  // One 16-bit frame; sclk levels last 6 clocks since the port is oversampled
  task automatic xfer(input logic [15:0] frm, output logic [7:0] dout);
    @(posedge clk);
    csb_n <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      host_sdio <= frm[i];
      repeat (5) @(posedge clk);
      @(negedge clk);
      if (i < 8) dout[i] = sdio_w;
      @(posedge clk);
      sclk <= 1'b1;
      repeat (6) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (6) @(posedge clk);
    csb_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    logic [7:0] x;
    xfer({3'h0, a, v}, x);
    repeat (4) @(posedge clk);
  endtask
  task automatic finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the roughly 7200 clocks the sequence needs
  initial
  begin
    #3000000;
    n_fail++;
    finish_test;
  end
  initial
  begin
    nrst = 1'b0; sclk = 1'b0; csb_n = 1'b1; host_sdio = 1'b0; tune = 3'h3;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    chk_all(16'h00e7, 16'h0442, 16'h001f, 16'h01f9, 16'h01f9, 16'h2400);
    foreach (rows[r])
    begin
      wr(rows[r][20:16], rows[r][15:8]);
      xfer({3'h4, rows[r][20:16], 8'h00}, d);
      chk("readback", {8'h0, d}, {8'h0, rows[r][7:0]});
    end
    chk_all(16'h00a5, 16'h1483, 16'h001f, 16'h0f5a, 16'h0f96, 16'h1b3c);
    // Every divider code with the multiplier on, then bypass
    for (int k = 0; k < 4; k++)
    begin
      wr(5'h09, {1'b1, k[1:0], k[1:0], 3'h3});
      @(negedge clk);
      chk("ratio", w_clk, {3'h0, 1'b1, 4'(1 << k), 5'(2 << k), 3'h3});
    end
    wr(5'h09, 8'h00);
    @(negedge clk);
    chk("bypass", w_clk, 16'h0110);
    // Single control bits alone, so swapped bits show
    wr(5'h0e, 8'h40);
    chk_all(16'h00a5, 16'h0110, 16'h001f, 16'h0f5a, 16'h0f96, 16'h2c3c);
    wr(5'h0e, 8'h20);
    wr(5'h0c, 8'h40);
    wr(5'h10, 8'h80);
    chk_all(16'h00a5, 16'h0110, 16'h001f, 16'h045a, 16'h0896, 16'h203c);
    chk("ipdn", w_i, 16'h045a);
    // Reset in mid-run restores every default
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    chk_all(16'h00e7, 16'h0442, 16'h001f, 16'h01f9, 16'h01f9, 16'h2400);
    // Recommended strength and bias settings take effect
    wr(5'h08, 8'h07);
    wr(5'h09, 8'h53);
    chk("drive", w_vco, 16'h0007);
    chk("bias", w_clk, 16'h0443);
    // Monitor field follows its input and ignores writes
    tune <= 3'h5;
    wr(5'h0a, 8'h0f);
    xfer({3'h4, 5'h0a, 8'h00}, d);
    chk("monitor", {8'h0, d}, 16'h00af);
    chk("bw", w_bw, 16'h000f);
    finish_test;
  end
endmodule
`default_nettype wire
